// File: verilog/lite_timer_pkg.sv
// Constants, register map and carrier types for the lite timebase/capture timer
package lite_timer_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] FIRST_CSR_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] SECOND_CSR_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] SECOND_CNT_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] SECOND_RELOAD_OFS = 8'h0C;
    localparam logic [ADDR_W-1:0] CAPTURE_VAL_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] CAPTURE_CSR_OFS = 8'h14;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 8'h18;
    localparam logic [ADDR_W-1:0] IRQ_CLEAR_OFS = 8'h1C;
    localparam logic [ADDR_W-1:0] IRQ_ENABLE_OFS = 8'h20;

    // Field positions in the control/status registers
    localparam int FIRST_IE_BIT = 0;
    localparam int FIRST_DOUBLE_BIT = 1;
    localparam int FIRST_FLAG_BIT = 2;
    localparam int SECOND_IE_BIT = 0;
    localparam int SECOND_FLAG_BIT = 1;
    localparam int CAPTURE_IE_BIT = 0;
    localparam int CAPTURE_FLAG_BIT = 1;

    // Event bit positions in status, clear and enable registers
    localparam int EV_FIRST = 0;
    localparam int EV_SECOND = 1;
    localparam int EV_CAPTURE = 2;
    localparam int NUM_EVENTS = 3;

    // Timebase figures
    localparam int PRESCALE_DIV = 32;
    localparam logic [CNT_W-1:0] CNT1_LAST = 8'hF9;
    localparam logic [CNT_W-1:0] CNT1_START = 8'h00;
    localparam logic [CNT_W-1:0] CNT2_LAST = 8'hFF;
    localparam logic [CNT_W-1:0] RELOAD_RESET = 8'h00;
    localparam int REF_OSC_KHZ = 8000;
    localparam int FIRST_PERIOD_US = 1000;
    localparam int FIRST_PERIOD_TICKS = FIRST_PERIOD_US * REF_OSC_KHZ / 1000 / PRESCALE_DIV;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [8:0] {
        SEL_NONE = 9'h000,
        SEL_FIRST_CSR = 9'h001,
        SEL_SECOND_CSR = 9'h002,
        SEL_SECOND_CNT = 9'h004,
        SEL_SECOND_RELOAD = 9'h008,
        SEL_CAPTURE_VAL = 9'h010,
        SEL_CAPTURE_CSR = 9'h020,
        SEL_IRQ_STATUS = 9'h040,
        SEL_IRQ_CLEAR = 9'h080,
        SEL_IRQ_ENABLE = 9'h100
    } reg_sel_t;

    typedef struct packed {
        logic period_double_select;
        logic capture_irq_enable;
        logic second_overflow_irq_enable;
        logic first_overflow_irq_enable;
    } ctrl_t;

endpackage : lite_timer_pkg

// File: verilog/timebase_prescaler.sv
// Divides the reference clock into a one-cycle tick every DIV enabled cycles
`timescale 1ns/100ps
module timebase_prescaler #(
    parameter int DIV = 32
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    output logic tick
);
    localparam int PW = $clog2(DIV);
    localparam logic [PW-1:0] LAST = PW'(DIV - 1);
    localparam logic [PW-1:0] ZERO = '0;
    localparam logic [PW-1:0] ONE = PW'(1);

    logic [PW-1:0] phase;

    initial
    begin
        if (DIV < 2)
            $error("timebase_prescaler: DIV must be at least 2");
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            phase <= ZERO;
        else if (clk_en)
            phase <= (phase == LAST) ? ZERO : phase + ONE;
    end

    // Tick belongs to the cycle in which the phase wraps
    assign tick = clk_en && (phase == LAST);
endmodule : timebase_prescaler

// File: verilog/pin_edge_detect.sv
// Two-flop synchroniser for an outside pin with any-edge detection
`timescale 1ns/100ps
module pin_edge_detect (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic pin,
    output logic edge_seen
);
    logic meta;
    logic level;
    logic level_prev;
    logic [1:0] armed;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            meta <= 1'b0;
            level <= 1'b0;
            level_prev <= 1'b0;
        end
        else if (clk_en)
        begin
            meta <= pin;
            level <= meta;
            level_prev <= level;
        end
    end

    // Masks edges for two enabled cycles after reset; a pin high at reset still shows one edge
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            armed <= 2'h0;
        else if (clk_en && !armed[1])
            armed <= {armed[0], 1'b1};
    end

    // Comparing two settled samples gives one pulse per edge
    assign edge_seen = clk_en && armed[1] && (level != level_prev);
endmodule : pin_edge_detect

// File: verilog/lite_timebase_capture_timer.sv
// Lite timer: two timebase counters, pin capture, AXI4-Lite registers, interrupt
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
module lite_timebase_capture_timer #(
    parameter int PRESCALE = lite_timer_pkg::PRESCALE_DIV
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic capture_input_pin,
    input wire logic [lite_timer_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [lite_timer_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [lite_timer_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [lite_timer_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic irq,
    output logic wake_req
);
    import lite_timer_pkg::*;

    initial
    begin
        if (PRESCALE < 2)
            $error("lite_timebase_capture_timer: PRESCALE must be at least 2");
        if (FIRST_PERIOD_TICKS != int'(CNT1_LAST) + 1)
            $error("lite_timebase_capture_timer: counter 1 modulus mismatch");
    end

    function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
        case (addr)
            FIRST_CSR_OFS: decode = SEL_FIRST_CSR;
            SECOND_CSR_OFS: decode = SEL_SECOND_CSR;
            SECOND_CNT_OFS: decode = SEL_SECOND_CNT;
            SECOND_RELOAD_OFS: decode = SEL_SECOND_RELOAD;
            CAPTURE_VAL_OFS: decode = SEL_CAPTURE_VAL;
            CAPTURE_CSR_OFS: decode = SEL_CAPTURE_CSR;
            IRQ_STATUS_OFS: decode = SEL_IRQ_STATUS;
            IRQ_CLEAR_OFS: decode = SEL_IRQ_CLEAR;
            IRQ_ENABLE_OFS: decode = SEL_IRQ_ENABLE;
            default: decode = SEL_NONE;
        endcase
    endfunction : decode

    logic tick;
    logic pin_edge;
    logic [CNT_W-1:0] first_count;
    logic [CNT_W-1:0] second_count;
    logic [CNT_W-1:0] reload_value;
    logic [CNT_W-1:0] capture_value;
    logic wrap_half;
    ctrl_t ctrl;
    logic [NUM_EVENTS-1:0] flags;
    logic [NUM_EVENTS-1:0] ev_set;
    logic [NUM_EVENTS-1:0] ev_clr;
    logic [NUM_EVENTS-1:0] enables;

    // Write channel state
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [DATA_W-1:0] w_data_q;
    logic [3:0] w_strb_q;
    logic do_write;
    reg_sel_t wr_sel;
    logic wr_lane0;
    logic [CNT_W-1:0] wr_byte;

    // Read channel state
    logic rd_take;
    reg_sel_t rd_sel;
    logic [DATA_W-1:0] next_rdata;

    timebase_prescaler #(
        .DIV(PRESCALE)
    ) u_prescaler (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .tick(tick)
    );

    pin_edge_detect u_pin_edge (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .pin(capture_input_pin),
        .edge_seen(pin_edge)
    );

    // AXI4-Lite write: address and data taken in any order, then one response
    assign awready = clk_en && !aw_held && !bvalid;
    assign wready = clk_en && !w_held && !bvalid;
    assign do_write = clk_en && aw_held && w_held;
    assign wr_sel = decode(aw_addr_q);
    assign wr_lane0 = w_strb_q[0];
    assign wr_byte = w_data_q[CNT_W-1:0];

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (awvalid && awready)
            begin
                aw_held <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_held <= 1'b1;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                bresp <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            end
            else if (bvalid && bready)
                bvalid <= 1'b0;
        end
    end

    // AXI4-Lite read: one outstanding, data registered on the accepting edge
    assign arready = clk_en && !rvalid;
    assign rd_take = arvalid && arready;
    assign rd_sel = decode(araddr);

    always_comb
    begin
        next_rdata = '0;
        case (rd_sel)
            SEL_FIRST_CSR:
            begin
                next_rdata[FIRST_IE_BIT] = ctrl.first_overflow_irq_enable;
                next_rdata[FIRST_DOUBLE_BIT] = ctrl.period_double_select;
                next_rdata[FIRST_FLAG_BIT] = flags[EV_FIRST];
            end
            SEL_SECOND_CSR:
            begin
                next_rdata[SECOND_IE_BIT] = ctrl.second_overflow_irq_enable;
                next_rdata[SECOND_FLAG_BIT] = flags[EV_SECOND];
            end
            SEL_SECOND_CNT: next_rdata[CNT_W-1:0] = second_count;
            SEL_SECOND_RELOAD: next_rdata[CNT_W-1:0] = reload_value;
            SEL_CAPTURE_VAL: next_rdata[CNT_W-1:0] = capture_value;
            SEL_CAPTURE_CSR:
            begin
                next_rdata[CAPTURE_IE_BIT] = ctrl.capture_irq_enable;
                next_rdata[CAPTURE_FLAG_BIT] = flags[EV_CAPTURE];
            end
            SEL_IRQ_STATUS: next_rdata[NUM_EVENTS-1:0] = flags;
            SEL_IRQ_ENABLE: next_rdata[NUM_EVENTS-1:0] = enables;
            default: next_rdata = '0;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (rd_take)
            begin
                rvalid <= 1'b1;
                rdata <= next_rdata;
                rresp <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            end
            else if (rvalid && rready)
                rvalid <= 1'b0;
        end
    end

    // Control bits; the enable register aliases the same storage
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            ctrl <= '0;
        else if (do_write && wr_lane0)
        begin
            case (wr_sel)
                SEL_FIRST_CSR:
                begin
                    ctrl.first_overflow_irq_enable <= wr_byte[FIRST_IE_BIT];
                    ctrl.period_double_select <= wr_byte[FIRST_DOUBLE_BIT];
                end
                SEL_SECOND_CSR: ctrl.second_overflow_irq_enable <= wr_byte[SECOND_IE_BIT];
                SEL_CAPTURE_CSR: ctrl.capture_irq_enable <= wr_byte[CAPTURE_IE_BIT];
                SEL_IRQ_ENABLE:
                begin
                    ctrl.first_overflow_irq_enable <= wr_byte[EV_FIRST];
                    ctrl.second_overflow_irq_enable <= wr_byte[EV_SECOND];
                    ctrl.capture_irq_enable <= wr_byte[EV_CAPTURE];
                end
                default: ctrl <= ctrl;
            endcase
        end
    end

    // Reload is only stored here; counter 2 picks it up at its next wrap
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            reload_value <= RELOAD_RESET;
        else if (do_write && wr_lane0 && wr_sel == SEL_SECOND_RELOAD)
            reload_value <= wr_byte;
    end

    // Counter 1: hidden, starts from zero, modulus 250
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            first_count <= CNT1_START;
        else if (tick)
            first_count <= (first_count == CNT1_LAST) ? CNT1_START : first_count + 8'h01;
    end

    // Counter rate stays fixed when doubled, so captures keep their resolution
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            wrap_half <= 1'b0;
        else if (tick && first_count == CNT1_LAST)
            wrap_half <= !wrap_half;
    end

    // Counter 2: readable, reloads from reload_value on passing FFh
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            second_count <= RELOAD_RESET;
        else if (tick)
            second_count <= (second_count == CNT2_LAST) ? reload_value : second_count + 8'h01;
    end

    // Event sources
    assign ev_set[EV_FIRST] = tick && first_count == CNT1_LAST
        && (!ctrl.period_double_select || wrap_half);
    assign ev_set[EV_SECOND] = tick && second_count == CNT2_LAST;
    // A clearing read in this cycle reopens capture, so the edge is not lost
    assign ev_set[EV_CAPTURE] = pin_edge && (!flags[EV_CAPTURE] || ev_clr[EV_CAPTURE]);

    // Clears: a read of the first or second CSR or of the capture value register, or a one written to the clear register
    assign ev_clr[EV_FIRST] = (rd_take && rd_sel == SEL_FIRST_CSR)
        || (do_write && wr_lane0 && wr_sel == SEL_IRQ_CLEAR && wr_byte[EV_FIRST]);
    assign ev_clr[EV_SECOND] = (rd_take && rd_sel == SEL_SECOND_CSR)
        || (do_write && wr_lane0 && wr_sel == SEL_IRQ_CLEAR && wr_byte[EV_SECOND]);
    assign ev_clr[EV_CAPTURE] = (rd_take && rd_sel == SEL_CAPTURE_VAL)
        || (do_write && wr_lane0 && wr_sel == SEL_IRQ_CLEAR && wr_byte[EV_CAPTURE]);

    // Sticky flags, set beats clear
    genvar gi;
    generate
        for (gi = 0; gi < NUM_EVENTS; gi++)
        begin : g_flag
            always_ff @(posedge ref_clk)
            begin
                if (sys_rst)
                    flags[gi] <= 1'b0;
                else if (ev_set[gi])
                    flags[gi] <= 1'b1;
                else if (ev_clr[gi])
                    flags[gi] <= 1'b0;
            end
        end
    endgenerate

    // Capture register holds the last accepted capture only
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            capture_value <= CNT1_START;
        else if (ev_set[EV_CAPTURE])
            capture_value <= first_count;
    end

    assign enables[EV_FIRST] = ctrl.first_overflow_irq_enable;
    assign enables[EV_SECOND] = ctrl.second_overflow_irq_enable;
    assign enables[EV_CAPTURE] = ctrl.capture_irq_enable;

    // Registered so the outputs are glitch-free; one cycle behind the flags
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            irq <= 1'b0;
            wake_req <= 1'b0;
        end
        else if (clk_en)
        begin
            irq <= |(flags & enables);
            wake_req <= flags[EV_CAPTURE] && ctrl.capture_irq_enable;
        end
    end
endmodule : lite_timebase_capture_timer

// File: verification/lite_timer_checker.sv
// Bus handshake and interrupt output checks for the lite timer
`timescale 1ns/100ps
module lite_timer_checker (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [lite_timer_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [lite_timer_pkg::DATA_W-1:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic irq,
    input wire logic wake_req
);
    import lite_timer_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    chk_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read not answered next cycle");
    chk_read_unmapped: assert property (arvalid && arready && araddr > IRQ_ENABLE_OFS
        |=> rresp == RESP_SLVERR && rdata == 32'h0)
        else $error("unmapped read not refused");
    chk_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read answer changed before taken");
    chk_write_resp: assert property (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
        else $error("write response timing wrong");
    chk_write_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response changed before taken");
    chk_resp_release: assert property (bvalid && bready |=> !bvalid)
        else $error("write response not released");
    chk_busy_refuse: assert property (bvalid |-> !awready && !wready && (!rvalid || !arready))
        else $error("request accepted while busy");
    chk_freeze_ready: assert property (!clk_en |-> !(awready || wready || arready))
        else $error("ready while clock disabled");
    chk_wake_irq: assert property (wake_req |-> irq)
        else $error("wake request without interrupt");
    chk_reset_quiet: assert property ($fell(sys_rst) |-> !irq && !wake_req && !rvalid && !bvalid)
        else $error("outputs active after reset");
endmodule : lite_timer_checker

bind lite_timebase_capture_timer lite_timer_checker chk_i (.ref_clk, .sys_rst, .clk_en,
    .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .irq, .wake_req);

// File: verification/capture_pin_source.sv
// Outside edge source driving the capture pin
`timescale 1ns/100ps
module capture_pin_source (
    input wire logic toggle,
    output logic pin
);
    initial pin = 1'b0;
    // Lands 7 ns after the request so the pin moves off the sampling edge
    always @(posedge toggle)
        pin <= #7 ~pin;
endmodule : capture_pin_source

// File: verification/testbench.sv
// Self-checking bench for the lite timebase/capture timer
`timescale 1ns/100ps
module testbench;
    import lite_timer_pkg::*;
    localparam int P = 2;
    logic ref_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, toggle = 1'b0, pin;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq, wake_req;
    logic [1:0] bresp, rresp;
    int error_cnt = 0, samples_checked = 0;

    lite_timebase_capture_timer #(.PRESCALE(P)) uut (.ref_clk, .sys_rst, .clk_en,
        .capture_input_pin(pin), .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .irq, .wake_req);
    capture_pin_source src (.toggle, .pin);

    initial
    begin
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic test_done();
        $display("checked %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic timeout();
        error_cnt++;
        $display("ERROR %0t wait ran out", $time);
        test_done();
    endtask : timeout

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit ah, wh, got;
        got = 0;
        // Callers may return on a falling edge; requests only start after a rising one
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 100 && !got; n++)
        begin
            @(negedge ref_clk);
            ah = (awready === 1'b1);
            wh = (wready === 1'b1);
            got = (bvalid === 1'b1);
            if (got) check({30'h0, bresp}, {30'h0, er});
            @(posedge ref_clk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
        end
        if (!got) timeout();
        bready <= 1'b0;
        @(posedge ref_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        bit ah, got;
        got = 0;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 100 && !got; n++)
        begin
            @(negedge ref_clk);
            ah = (arready === 1'b1);
            got = (rvalid === 1'b1);
            d = rdata;
            if (got) check({30'h0, rresp}, {30'h0, er});
            @(posedge ref_clk);
            if (ah) arvalid <= 1'b0;
        end
        if (!got) timeout();
        rready <= 1'b0;
        @(posedge ref_clk);
    endtask : rd

    task automatic wait_irq(input logic lvl, input int lim);
        int n;
        n = 0;
        do
        begin
            @(negedge ref_clk);
            n++;
        end
        while (irq !== lvl && n < lim);
        if (irq !== lvl) timeout();
    endtask : wait_irq

    // Rise to rise of irq, clearing the flag by a read of csr in between
    task automatic period(input logic [7:0] csr, output int p);
        realtime t0;
        logic [31:0] d;
        rd(csr, d, RESP_OKAY);
        wait_irq(1'b0, 10);
        wait_irq(1'b1, 2200);
        t0 = $realtime;
        rd(csr, d, RESP_OKAY);
        wait_irq(1'b0, 10);
        wait_irq(1'b1, 2200);
        p = int'(($realtime - t0) / 20.0);
    endtask : period

    task automatic pulse();
        toggle <= 1'b1;
        @(posedge ref_clk);
        toggle <= 1'b0;
        @(posedge ref_clk);
    endtask : pulse

    task automatic t_regs();
        logic [7:0] a[7] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20};
        logic [31:0] d;
        foreach (a[i])
        begin
            rd(a[i], d, RESP_OKAY);
            check(d, 32'h0);
        end
        rd(8'h24, d, RESP_SLVERR);
        check(d, 32'h0);
        wr(8'h24, 32'hFF, RESP_SLVERR);
        wr(SECOND_RELOAD_OFS, 32'hA5, RESP_OKAY);
        rd(SECOND_RELOAD_OFS, d, RESP_OKAY);
        check(d, 32'hA5);
        wr(IRQ_ENABLE_OFS, 32'h4, RESP_OKAY);
        rd(CAPTURE_CSR_OFS, d, RESP_OKAY);
        check(d, 32'h1);
        wr(IRQ_ENABLE_OFS, 32'h0, RESP_OKAY);
        clk_en <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check({29'h0, awready, wready, arready}, 32'h0);
        clk_en <= 1'b1;
        $display("registers test done");
    endtask : t_regs

    task automatic t_first();
        int p, hits;
        logic [31:0] d;
        wr(FIRST_CSR_OFS, 32'h1, RESP_OKAY);
        period(FIRST_CSR_OFS, p);
        check(32'(p), 32'(250 * P));
        rd(FIRST_CSR_OFS, d, RESP_OKAY);
        check(d, 32'h5);
        rd(FIRST_CSR_OFS, d, RESP_OKAY);
        check(d, 32'h1);
        wr(FIRST_CSR_OFS, 32'h3, RESP_OKAY);
        period(FIRST_CSR_OFS, p);
        check(32'(p), 32'(500 * P));
        wr(FIRST_CSR_OFS, 32'h0, RESP_OKAY);
        rd(FIRST_CSR_OFS, d, RESP_OKAY);
        hits = 0;
        repeat (520 * P)
        begin
            @(negedge ref_clk);
            if (irq !== 1'b0) hits++;
        end
        check(32'(hits), 32'h0);
        rd(IRQ_STATUS_OFS, d, RESP_OKAY);
        check({31'h0, d[0]}, 32'h1);
        wr(IRQ_CLEAR_OFS, 32'h1, RESP_OKAY);
        rd(IRQ_STATUS_OFS, d, RESP_OKAY);
        check({31'h0, d[0]}, 32'h0);
        rd(FIRST_CSR_OFS, d, RESP_OKAY);
        $display("first counter test done");
    endtask : t_first

    task automatic t_second();
        int p;
        logic [31:0] d;
        wr(SECOND_RELOAD_OFS, 32'hF0, RESP_OKAY);
        wr(SECOND_CSR_OFS, 32'h1, RESP_OKAY);
        period(SECOND_CSR_OFS, p);
        check(32'(p), 32'(16 * P));
        wr(SECOND_RELOAD_OFS, 32'h00, RESP_OKAY);
        rd(SECOND_CNT_OFS, d, RESP_OKAY);
        check({28'h0, d[7:4]}, 32'hF);
        period(SECOND_CSR_OFS, p);
        check(32'(p), 32'(256 * P));
        wr(SECOND_CSR_OFS, 32'h0, RESP_OKAY);
        $display("second counter test done");
    endtask : t_second

    task automatic t_capture();
        logic [31:0] d, v1, v2;
        wr(CAPTURE_CSR_OFS, 32'h1, RESP_OKAY);
        rd(CAPTURE_VAL_OFS, d, RESP_OKAY);
        pulse();
        wait_irq(1'b1, 20);
        check({31'h0, wake_req}, 32'h1);
        rd(CAPTURE_CSR_OFS, d, RESP_OKAY);
        check(d, 32'h3);
        rd(CAPTURE_VAL_OFS, v1, RESP_OKAY);
        check(32'(v1[7:0] < 8'hFA), 32'h1);
        wait_irq(1'b0, 10);
        pulse();
        wait_irq(1'b1, 20);
        // A late edge while the flag stands would pull v1 close to v2 if taken
        repeat (40) @(posedge ref_clk);
        pulse();
        repeat (20) @(posedge ref_clk);
        rd(CAPTURE_VAL_OFS, v1, RESP_OKAY);
        pulse();
        wait_irq(1'b1, 20);
        rd(CAPTURE_VAL_OFS, v2, RESP_OKAY);
        check(32'((int'(v2[7:0]) - int'(v1[7:0]) + 250) % 250 > 24), 32'h1);
        repeat (20) @(negedge ref_clk);
        check({31'h0, irq}, 32'h0);
        $display("capture test done");
    endtask : t_capture

    initial
    begin
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        t_regs();
        t_first();
        t_second();
        t_capture();
        test_done();
    end
endmodule : testbench
